// *** pfos_top.sv ***
/*
 * PWM fault source selection and output override for one generator.
 * Assumes a register master on the plain strobe port, PWM drive levels and
 * a cycle boundary pulse from the generator on core_clk, and fault pins
 * and comparator outputs asynchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module pfos_top
	import pfos_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output var  logic [15:0] reg_rdata,
	input  wire logic [3:0]  fault_in,
	input  wire logic [3:0]  comparator_in,
	input  wire logic        fault_default_in,
	input  wire logic        pwm_write_lock_config,
	input  wire logic        pwm_timebase_enable,
	input  wire logic        pwm_high_in,
	input  wire logic        pwm_low_in,
	input  wire logic        pwm_cycle_boundary,
	output var  logic        pwm_high_output,
	output var  logic        pwm_low_output,
	output var  logic        fault_override_active
);

	// ==========================================================
	// Input synchronisation
	pfos_src_t src_raw;
	pfos_src_t src_sync;

	assign src_raw = '{dflt: fault_default_in, cmp: comparator_in, ext: fault_in};

	pfos_sync #(.WIDTH(9)) u_sync
	(
		.core_clk (core_clk),
		.resetn   (resetn),
		.async_in (src_raw),
		.sync_out (src_sync)
	);

	// ==========================================================
	// Source decode: {valid, raw level}
	function automatic logic [1:0] pfos_pick(input logic [4:0] code, input pfos_src_t s);
		logic [1:0] r;
		r = 2'b00;
		if (code <= PFOS_SRC_FAULT4)
			r = {1'b1, s.ext[code[1:0]]};
		else if (code >= PFOS_SRC_CMP1 && code <= PFOS_SRC_CMP4)
			r = {1'b1, s.cmp[code[1:0]]};
		else if (code == PFOS_SRC_DEFAULT)
			r = {1'b1, s.dflt};
		return r;
	endfunction

	// ==========================================================
	// Registers and state
	pfos_fctl_t fctl;
	pfos_pair_t ovr;
	pfos_ul_t   ul_state;
	logic       lock_cfg;
	logic       strap_taken;
	logic       latch_hold;
	logic       cycle_hold;

	// Access decode
	wire wr_fctl = reg_write && reg_addr == PFOS_ADDR_FCTL;
	wire wr_octl = reg_write && reg_addr == PFOS_ADDR_OCTL;
	wire wr_key  = reg_write && reg_addr == PFOS_ADDR_KEY;
	wire wr_stat = reg_write && reg_addr == PFOS_ADDR_STAT;

	// Fault evaluation
	wire [1:0] picked      = pfos_pick(fctl.src, src_sync);
	wire       src_valid   = picked[1];
	wire       src_level   = picked[0];
	wire       src_assert  = src_valid && (src_level ^ fctl.pol);
	wire       mode_latch  = fctl.mode == PFOS_MODE_LATCHED;
	wire       mode_cycle  = fctl.mode == PFOS_MODE_CYCLE;
	wire       fault_live  = src_assert && (mode_latch || mode_cycle);
	wire       override_now = fault_live || latch_hold || cycle_hold;

	// Lock and key handling
	wire lock_open  = !lock_cfg || ul_state == PFOS_UL_OPEN;
	wire octl_taken = wr_octl && lock_open;
	wire key_first  = wr_key && reg_wdata == PFOS_KEY_FIRST;
	wire key_second = wr_key && reg_wdata == PFOS_KEY_SECOND;

	// Next values
	wire next_latch = (fault_live && mode_latch) ||
		(latch_hold && !(wr_stat && reg_wdata[PFOS_STAT_LATCH]));
	wire next_cycle = (fault_live && mode_cycle) ||
		(cycle_hold && !pwm_cycle_boundary);
	wire next_high  = override_now ? ovr.high : pwm_high_in;
	wire next_low   = override_now ? ovr.low : pwm_low_in;

	// Key sequence: two consecutive key writes open one output-control write
	pfos_ul_t next_ul;
	always_comb
	begin
		next_ul = ul_state;
		unique case (ul_state)
			PFOS_UL_LOCKED:
				if (key_first)
					next_ul = PFOS_UL_KEY1;
			PFOS_UL_KEY1:
				if (key_second)
					next_ul = PFOS_UL_OPEN;
				else if (reg_write)
					next_ul = key_first ? PFOS_UL_KEY1 : PFOS_UL_LOCKED;
			PFOS_UL_OPEN:
				if (wr_octl)
					next_ul = PFOS_UL_LOCKED; // One write per unlock
			default:
				next_ul = PFOS_UL_LOCKED;
		endcase
	end

	// Status word; bit 6 mirrors the time base so software can see when a
	// polarity edit is unsafe, the block itself never blocks the edit
	wire [15:0] stat_word = {9'h000, pwm_timebase_enable, override_now,
		ul_state == PFOS_UL_OPEN, lock_cfg, src_assert, cycle_hold, latch_hold};

	// Read mux on the strobe's address; unmapped addresses read as zero
	wire [15:0] rd_mux =
		(reg_addr == PFOS_ADDR_FCTL) ? {8'h00, fctl} :
		(reg_addr == PFOS_ADDR_OCTL) ? {14'h0000, ovr} :
		(reg_addr == PFOS_ADDR_STAT) ? stat_word : 16'h0000;

	// Configuration registers
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			fctl <= pfos_fctl_t'(PFOS_FCTL_RESET);
			ovr  <= pfos_pair_t'(PFOS_OCTL_RESET);
		end
		else
		begin
			if (wr_fctl)
				fctl <= pfos_fctl_t'(reg_wdata[7:0]);
			if (octl_taken)
				ovr <= pfos_pair_t'(reg_wdata[1:0]);
		end
	end

	// Lock strap caught after release; locked until then, the safe side
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			lock_cfg    <= 1'b1;
			strap_taken <= 1'b0;
			ul_state    <= PFOS_UL_LOCKED;
		end
		else
		begin
			strap_taken <= 1'b1;
			if (!strap_taken)
				lock_cfg <= pwm_write_lock_config;
			ul_state <= next_ul;
		end
	end

	// Override holds; a new fault beats a clear in the same cycle
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			latch_hold <= 1'b0;
			cycle_hold <= 1'b0;
		end
		else
		begin
			latch_hold <= next_latch;
			cycle_hold <= next_cycle;
		end
	end

	// Output pins registered so the pins never glitch on a decode change
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pwm_high_output       <= 1'b0;
			pwm_low_output        <= 1'b0;
			fault_override_active <= 1'b0;
		end
		else
		begin
			pwm_high_output       <= next_high;
			pwm_low_output        <= next_low;
			fault_override_active <= override_now;
		end
	end

	// Read data registered at the strobe edge, so it stands only in the next cycle
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= 16'h0000;
		else if (reg_read)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= 16'h0000; // Zero outside the one answer cycle
	end

	// ==========================================================
	// Assertions
	sequence s_key_pair;
		key_first ##1 key_second;
	endsequence

	sequence s_cycle_release;
		cycle_hold && pwm_cycle_boundary && !fault_live;
	endsequence

	property p_reserved_quiet;
		@(posedge core_clk) disable iff (!resetn)
		(fctl.src > PFOS_SRC_FAULT4 && fctl.src < PFOS_SRC_CMP1) ||
		(fctl.src > PFOS_SRC_CMP4 && fctl.src < PFOS_SRC_DEFAULT) |-> !src_assert;
	endproperty

	a_reserved_src_quiet: assert property (p_reserved_quiet)
		else $error("reserved selector asserted a fault");

	a_ext_fault_route: assert property (@(posedge core_clk) disable iff (!resetn)
		fctl.src <= PFOS_SRC_FAULT4 |-> src_level == src_sync.ext[fctl.src[1:0]])
		else $error("external fault routing wrong");

	a_cmp_route_pick: assert property (@(posedge core_clk) disable iff (!resetn)
		fctl.src >= PFOS_SRC_CMP1 && fctl.src <= PFOS_SRC_CMP4
		|-> src_valid && src_level == src_sync.cmp[fctl.src[1:0]])
		else $error("comparator routing wrong");

	a_polarity_sense: assert property (@(posedge core_clk) disable iff (!resetn)
		src_valid |-> src_assert == (fctl.pol ? !src_level : src_level))
		else $error("fault polarity not applied");

	a_mode_off_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
		fctl.mode[1] && !latch_hold && !cycle_hold |-> !override_now)
		else $error("disabled mode still overrides");

	a_cycle_force_pins: assert property (@(posedge core_clk) disable iff (!resetn)
		mode_cycle && src_assert |=> pwm_high_output == $past(ovr.high) &&
		pwm_low_output == $past(ovr.low) && fault_override_active)
		else $error("cycle mode did not force outputs");

	a_latch_hold_on: assert property (@(posedge core_clk) disable iff (!resetn)
		mode_latch && src_assert ##1 !(wr_stat && reg_wdata[PFOS_STAT_LATCH])
		|=> latch_hold && fault_override_active)
		else $error("latched fault did not hold");

	a_lock_reject_write: assert property (@(posedge core_clk) disable iff (!resetn)
		wr_octl && lock_cfg && ul_state != PFOS_UL_OPEN |=> $stable(ovr))
		else $error("locked output control was written");

	a_unlock_opens: assert property (@(posedge core_clk) disable iff (!resetn)
		s_key_pair |=> ul_state == PFOS_UL_OPEN)
		else $error("key sequence did not unlock");

	a_cycle_release_edge: assert property (@(posedge core_clk) disable iff (!resetn)
		s_cycle_release |=> !cycle_hold)
		else $error("cycle override not released at boundary");

	a_cycle_hold_keep: assert property (@(posedge core_clk) disable iff (!resetn)
		cycle_hold && !pwm_cycle_boundary |=> cycle_hold [*1])
		else $error("cycle override dropped mid-cycle");

	a_latch_clear_frees: assert property (@(posedge core_clk) disable iff (!resetn)
		latch_hold && wr_stat && reg_wdata[PFOS_STAT_LATCH] && !(fault_live && mode_latch)
		|=> !latch_hold)
		else $error("latch clear did not release");

	a_pins_follow_idle: assert property (@(posedge core_clk) disable iff (!resetn)
		!override_now |=> pwm_high_output == $past(pwm_high_in) &&
		pwm_low_output == $past(pwm_low_in) && !fault_override_active)
		else $error("outputs did not follow generator drive");

	a_unlock_single: assert property (@(posedge core_clk) disable iff (!resetn)
		ul_state == PFOS_UL_OPEN && wr_octl |=> ul_state == PFOS_UL_LOCKED)
		else $error("unlock window allowed a second write");

endmodule

`default_nettype wire

// *** pfos_pkg.sv ***
/*
 * Constants and types for the PWM fault source select and override block.
 * Assumes a single core clock domain; every user includes this package.
 */
package pfos_pkg;

	// ==========================================================
	// Register map (byte addresses, 32-bit aligned words)
	localparam logic [7:0]  PFOS_ADDR_FCTL = 8'h00; // Fault limit control
	localparam logic [7:0]  PFOS_ADDR_OCTL = 8'h04; // Output control (override values)
	localparam logic [7:0]  PFOS_ADDR_KEY  = 8'h08; // Unlock key, write only
	localparam logic [7:0]  PFOS_ADDR_STAT = 8'h0C; // Status, read; write 1 clears latch

	// ==========================================================
	// Field positions
	localparam int          PFOS_FCTL_SRC_LSB  = 3;
	localparam int          PFOS_FCTL_POL_BIT  = 2;
	localparam int          PFOS_FCTL_MODE_LSB = 0;
	localparam int          PFOS_OCTL_HIGH_BIT = 0;
	localparam int          PFOS_OCTL_LOW_BIT  = 1;
	localparam int          PFOS_STAT_LATCH    = 0;
	localparam int          PFOS_STAT_CYCLE    = 1;
	localparam int          PFOS_STAT_SRC      = 2;
	localparam int          PFOS_STAT_LOCKCFG  = 3;
	localparam int          PFOS_STAT_OPEN     = 4;
	localparam int          PFOS_STAT_OVR      = 5;

	// ==========================================================
	// Source selector codes
	localparam logic [4:0]  PFOS_SRC_FAULT1  = 5'h00;
	localparam logic [4:0]  PFOS_SRC_FAULT4  = 5'h03;
	localparam logic [4:0]  PFOS_SRC_CMP1    = 5'h08;
	localparam logic [4:0]  PFOS_SRC_CMP4    = 5'h0B;
	localparam logic [4:0]  PFOS_SRC_DEFAULT = 5'h1F;

	// ==========================================================
	// Unlock keys and reset values
	localparam logic [15:0] PFOS_KEY_FIRST   = 16'h0055;
	localparam logic [15:0] PFOS_KEY_SECOND  = 16'h00AA;
	localparam logic [7:0]  PFOS_FCTL_RESET  = 8'hFB; // Default source, fault disabled
	localparam logic [1:0]  PFOS_OCTL_RESET  = 2'h0;

	// ==========================================================
	// Types
	typedef enum logic [1:0]
	{
		PFOS_MODE_LATCHED = 2'b00,
		PFOS_MODE_CYCLE   = 2'b01,
		PFOS_MODE_RSVD    = 2'b10,
		PFOS_MODE_OFF     = 2'b11
	} pfos_mode_t;

	typedef enum logic [1:0]
	{
		PFOS_UL_LOCKED = 2'b00,
		PFOS_UL_KEY1   = 2'b01,
		PFOS_UL_OPEN   = 2'b10
	} pfos_ul_t;

	typedef struct packed
	{
		logic [4:0] src;
		logic       pol;
		pfos_mode_t mode;
	} pfos_fctl_t;

	typedef struct packed
	{
		logic low;
		logic high;
	} pfos_pair_t;

	typedef struct packed
	{
		logic       dflt;
		logic [3:0] cmp;
		logic [3:0] ext;
	} pfos_src_t;

endpackage

// *** pfos_sync.sv ***
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes inputs are asynchronous to core_clk; output updates when stages
 * two and three agree.
 */
`timescale 1ns/1ps
`default_nettype none

module pfos_sync
	import pfos_pkg::*;
#(
	parameter int WIDTH = 9
)
(
	input  wire logic             core_clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	// ==========================================================
	// Stages
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);
	wire  [WIDTH-1:0] next_sync_out = (agree & stage3) | (~agree & sync_out);

	// Stage one feeds only stage two, to keep metastability contained
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			stage1   <= '0;
			stage2   <= '0;
			stage3   <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1   <= async_in;
			stage2   <= stage1;
			stage3   <= stage2;
			sync_out <= next_sync_out;
		end
	end

endmodule

`default_nettype wire

// *** pfos_fault_model.sv ***
/*
 * Model of the fault pins and comparator outputs for the bench.
 * Assumes the bench sets the wanted levels; pins follow off the clock grid.
 */
`timescale 1ns/1ps
`default_nettype none

module pfos_fault_model
#(
	parameter int DLY_NS = 17
)
(
	input  wire logic [8:0] want,
	output var  logic [3:0] fault_in,
	output var  logic [3:0] comparator_in,
	output var  logic       fault_default_in
);
	// ==========================================
	// Async sources: delay keeps edges away from core_clk
	always @(want)
	begin
		{fault_default_in, comparator_in, fault_in} <= #(DLY_NS) want;
	end
endmodule
`default_nettype wire

// *** pfos_top_tb.sv ***
/*
 * Self-checking bench: register port, source codes, polarity, modes,
 * latch clear and output-control lock.
 * Assumes one 20 MHz clock and read data one cycle after the strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module pfos_top_tb
	import pfos_pkg::*;
;
	logic        core_clk  = 1'b0;
	logic        resetn    = 1'b0;
	logic [7:0]  reg_addr  = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_write = 1'b0;
	logic        reg_read  = 1'b0;
	logic [15:0] reg_rdata;
	logic [8:0]  want      = 9'h000;
	logic [3:0]  fault_in;
	logic [3:0]  comparator_in;
	logic        fault_default_in;
	logic        lock_cfg  = 1'b0;
	logic        tb_en     = 1'b0;
	logic        hi_in     = 1'b0;
	logic        lo_in     = 1'b0;
	logic        boundary  = 1'b0;
	logic        pwm_h;
	logic        pwm_l;
	logic        ovr_act;
	logic        pin_chk   = 1'b0;
	logic        rd_q      = 1'b0;
	logic        pin_q     = 1'b0;
	logic [1:0]  ovr       = 2'h0;
	logic [15:0] seed      = 16'h3F12;
	logic [15:0] exp_q[$];
	logic [15:0] exp_v;
	logic [15:0] got;
	int          fail_count = 0;
	int          checks     = 0;
	int          cyc        = 0;
	logic [4:0]  codes [13] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0A,
		5'h0B, 5'h1F, 5'h04, 5'h07, 5'h0C, 5'h1E};

	always #25 core_clk = ~core_clk;

	pfos_fault_model src_u (.want(want), .fault_in(fault_in),
		.comparator_in(comparator_in), .fault_default_in(fault_default_in));

	pfos_top dut_u (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .fault_in(fault_in), .comparator_in(comparator_in),
		.fault_default_in(fault_default_in), .pwm_write_lock_config(lock_cfg),
		.pwm_timebase_enable(tb_en), .pwm_high_in(hi_in), .pwm_low_in(lo_in),
		.pwm_cycle_boundary(boundary), .pwm_high_output(pwm_h),
		.pwm_low_output(pwm_l), .fault_override_active(ovr_act));

	// ==========================================
	// Watcher: oldest note against what appeared; also the hang limit
	always @(posedge core_clk)
	begin
		if (rd_q || pin_q)
		begin
			exp_v = exp_q.pop_front();
			got = rd_q ? reg_rdata : {13'h0000, ovr_act, pwm_l, pwm_h};
			checks++;
			if (got !== exp_v)
			begin
				fail_count++;
				$display("BAD t=%0t exp=%h got=%h", $time, exp_v, got);
			end
		end
		rd_q <= reg_read;
		pin_q <= pin_chk;
		cyc++;
		if (cyc > 5000)
		begin
			fail_count++;
			end_sim();
		end
	end

	function automatic logic [15:0] xs(input logic [15:0] x);
		x = x ^ (x << 7);
		x = x ^ (x >> 9);
		return x ^ (x << 8);
	endfunction

	// Pin bit of a functional code: ext 0..3, cmp 4..7, default 8
	function automatic logic [8:0] wsel(input logic [4:0] s);
		return (s == 5'h1F) ? 9'h100 : 9'h001 << (s[3] ? s - 5'd4 : s);
	endfunction

	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		step(1);
		reg_write <= 1'b0;
		step(1);
	endtask

	// Two writes back to back: strobe held up across both edges
	task automatic wr2(input logic [7:0] a, input logic [15:0] d1, input logic [15:0] d2);
		reg_addr <= a;
		reg_wdata <= d1;
		reg_write <= 1'b1;
		step(1);
		reg_wdata <= d2;
		step(1);
		reg_write <= 1'b0;
		step(1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		reg_addr <= a;
		reg_read <= 1'b1;
		step(1);
		reg_read <= 1'b0;
		step(1);
	endtask

	task automatic pin(input logic [2:0] e);
		exp_q.push_back({13'h0000, e});
		pin_chk <= 1'b1;
		step(1);
		pin_chk <= 1'b0;
		step(1);
	endtask

	task automatic do_reset(input logic lk);
		resetn <= 1'b0;
		lock_cfg <= lk;
		step(5);
		resetn <= 1'b1;
		step(2);
	endtask

	// Assert source, clear it, then cross one cycle boundary
	task automatic fcase(input logic [4:0] s, input logic pol, input logic [1:0] m,
		input logic [8:0] w, input logic hit);
		logic [2:0] on;
		logic [2:0] off;
		on = {1'b1, ovr};
		off = {1'b0, lo_in, hi_in};
		wr(PFOS_ADDR_FCTL, {8'h00, s, pol, m});
		want <= pol ? ~w : w;
		step(8);
		pin(hit ? on : off);
		want <= pol ? 9'h1FF : 9'h000;
		step(8);
		pin(hit ? on : off);
		boundary <= 1'b1;
		step(1);
		boundary <= 1'b0;
		step(3);
		pin((hit && m == 2'b00) ? on : off);
	endtask

	task automatic end_sim();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ==========================================
	// Main sequence; time base stays off until the final status read, so polarity edits are safe
	initial
	begin
		do_reset(1'b0);
		rd(PFOS_ADDR_FCTL, {8'h00, PFOS_FCTL_RESET});
		rd(PFOS_ADDR_KEY, 16'h0000);
		rd(8'h10, 16'h0000);
		seed = xs(seed);
		hi_in <= seed[4];
		lo_in <= seed[9];
		ovr = ~{seed[9], seed[4]};
		wr(PFOS_ADDR_OCTL, {14'h0000, ovr});
		rd(PFOS_ADDR_OCTL, {14'h0000, ovr});
		for (int i = 0; i < 13; i++)
		begin
			fcase(codes[i], 1'b0, 2'b01, i < 9 ? wsel(codes[i]) : 9'h1FF, i < 9);
		end
		fcase(PFOS_SRC_FAULT1, 1'b0, 2'b11, 9'h001, 1'b0);
		fcase(PFOS_SRC_FAULT1, 1'b0, 2'b10, 9'h001, 1'b0);
		fcase(PFOS_SRC_FAULT4, 1'b0, 2'b00, 9'h008, 1'b1);
		rd(PFOS_ADDR_STAT, 16'h0021);
		wr(PFOS_ADDR_STAT, 16'h0001);
		step(4);
		pin({1'b0, lo_in, hi_in});
		fcase(PFOS_SRC_CMP4, 1'b1, 2'b01, wsel(PFOS_SRC_CMP4), 1'b1);
		// Locked strap: key pair opens a single output-control write
		want <= 9'h000;
		do_reset(1'b1);
		rd(PFOS_ADDR_STAT, 16'h0008);
		wr(PFOS_ADDR_OCTL, 16'h0003);
		rd(PFOS_ADDR_OCTL, 16'h0000);
		wr(PFOS_ADDR_KEY, PFOS_KEY_FIRST);
		wr(PFOS_ADDR_FCTL, {8'h00, PFOS_FCTL_RESET});
		wr(PFOS_ADDR_KEY, PFOS_KEY_SECOND);
		wr(PFOS_ADDR_OCTL, 16'h0003);
		rd(PFOS_ADDR_OCTL, 16'h0000);
		wr2(PFOS_ADDR_KEY, PFOS_KEY_FIRST, PFOS_KEY_SECOND);
		wr2(PFOS_ADDR_OCTL, 16'h0002, 16'h0001);
		rd(PFOS_ADDR_OCTL, 16'h0002);
		tb_en <= 1'b1;
		rd(PFOS_ADDR_STAT, 16'h0048);
		step(3);
		end_sim();
	end
endmodule
`default_nettype wire
